// ===== verilog/cfpm_pkg.sv
package cfpm_pkg;
   // register offsets (8-bit command codes)
   localparam logic [7:0]  REG_STATUS_INFO   = 8'h3A;
   localparam logic [7:0]  REG_FIRST_CTRL    = 8'h3C;
   localparam logic [7:0]  REG_SECOND_CTRL   = 8'h3D;
   // field positions
   localparam int          CTL1_OTG_EN_BIT   = 11;
   localparam int          CTL2_CMP_DIS_BIT  = 3;
   localparam int          CTL2_CMP_INV_BIT  = 2;
   localparam int          CTL2_GUARD_OFF    = 1;
   localparam int          CTL2_SHORT_DEB    = 11;
   localparam int          INFO_MODE_LO      = 5;
   localparam int          INFO_MODE_HI      = 6;
   localparam logic [1:0]  INFO_MODE_OTG     = 2'h3;
   // reset values
   localparam logic [15:0] CTL1_RESET        = 16'h0000;
   localparam logic [15:0] CTL2_RESET        = 16'h0000;
   // clock and timing
   localparam longint      CLK_HZ            = 10000000;
   localparam longint      AIN_QUAL_NS       = 10000;
   localparam longint      AIN_REL_NS        = 100000;
   localparam longint      GUARD_SAMPLE_NS   = 20000;
   localparam longint      GUARD_WIN_MS      = 656;
   localparam longint      DEB_LONG_MS       = 1300;
   localparam longint      DEB_SHORT_MS      = 150;
   localparam longint      TEMP_DELAY_NS     = 100000;
   // cycle counts: least times round up
   localparam int AIN_QUAL_CYC  = int'((AIN_QUAL_NS * CLK_HZ + 999999999) / 1000000000);
   localparam int AIN_REL_CYC   = int'((AIN_REL_NS * CLK_HZ + 999999999) / 1000000000);
   localparam int GUARD_SMP_CYC = int'((GUARD_SAMPLE_NS * CLK_HZ + 999999999) / 1000000000);
   localparam int TEMP_DLY_CYC  = int'((TEMP_DELAY_NS * CLK_HZ + 999999999) / 1000000000);
   localparam int GUARD_WIN_CYC = int'(GUARD_WIN_MS * CLK_HZ / 1000);
   localparam int DEB_LONG_CYC  = int'(DEB_LONG_MS * CLK_HZ / 1000);
   localparam int DEB_SHORT_CYC = int'(DEB_SHORT_MS * CLK_HZ / 1000);
   localparam int GUARD_LIMIT   = 7;
   // overcurrent guard states
   typedef enum logic [1:0] {GRD_RUN, GRD_TRIP, GRD_RETRY} cfpm_guard_t;
endpackage : cfpm_pkg

// ===== verilog/cfpm_qualifier.sv
`timescale 1ns/1ps
// holds a level for a count of cycles before passing it on
module cfpm_qualifier
   import cfpm_pkg::*;
#(
   parameter int CYCLES = 100
)
(
   // clock and reset
   input  wire logic ref_clk_in,
   input  wire logic rst_in,
   // condition and result
   input  wire logic cond_in,
   output logic      met_out
);
   logic [31:0] cnt_ff;      // cycles the condition has held
   logic [31:0] nxt_cnt;     // next count
   logic        met_ff;      // qualified result
   logic        nxt_met;     // next result

   // count while held, clear when dropped; qualify strictly after CYCLES
   assign nxt_cnt = !cond_in ? 32'h00000000 :
                    (cnt_ff > 32'(CYCLES)) ? cnt_ff : cnt_ff + 32'h00000001;
   assign nxt_met = cond_in && (cnt_ff >= 32'(CYCLES));

   // count register
   always_ff @(posedge ref_clk_in)
   begin
      if (rst_in)
      begin
         cnt_ff <= 32'h00000000;
         met_ff <= 1'b0;
      end
      else
      begin
         cnt_ff <= nxt_cnt;
         met_ff <= nxt_met;
      end
   end

   assign met_out = met_ff;
endmodule : cfpm_qualifier

// ===== verilog/cfpm_top.sv
`timescale 1ns/1ps
// What this block does
// - otg off, comparator off bit clear: comparator pins
// - otg off, comparator disabled: pins idle
// - otg on, comparator on: otg above battery limit
// - otg active reports mode field 11
// - both set: enable pin input, power-good output
// - adapter overvoltage after qualification time above threshold
// - overvoltage: open gate, flag low, stop, battery
// - release after recovery time below lower threshold
// - system overvoltage stops switching
// - system overvoltage clears at hysteresis, no debounce
// - overcurrent trips on adapter or battery limit
// - at most one count per sampling interval
// - seven counts in window: shut down immediately
// - debounce long or short, then restart
// - over-temperature turns regulator off, stops switching
// - regulator stays off until below release point
// - fixed delay before regulator returns
// - bit selects comparator output polarity
// - power-good high inside output voltage window
module cfpm_top
   import cfpm_pkg::*;
#(
   parameter int WIN_CYC   = GUARD_WIN_CYC,   // counting window
   parameter int LONG_CYC  = DEB_LONG_CYC,    // long debounce
   parameter int SHORT_CYC = DEB_SHORT_CYC    // short debounce
)
(
   // clock and reset
   input  wire logic        ref_clk_in,
   input  wire logic        rst_in,
   // register port
   input  wire logic        reg_wr_in,
   input  wire logic [7:0]  reg_addr_in,
   input  wire logic [15:0] reg_wdata_in,
   output logic [15:0]      reg_rdata_out,
   // analog comparator levels
   input  wire logic        ain_over_in,        // adapter above upper threshold
   input  wire logic        ain_below_rel_in,   // adapter below release threshold
   input  wire logic        sys_over_in,        // rail above ceiling plus margin
   input  wire logic        sys_below_hys_in,   // rail below threshold minus hysteresis
   input  wire logic        adp_cur_over_in,    // adapter current above its limit
   input  wire logic        bat_cur_over_in,    // discharge current above its limit
   input  wire logic        temp_hot_in,        // junction above upper trip
   input  wire logic        temp_cool_in,       // junction below release point
   input  wire logic        bat_above_otg_in,   // battery above otg limit
   input  wire logic        otg_in_window_in,   // otg output inside valid window
   input  wire logic        cmp_above_ref_in,   // comparator input above reference
   // shared pins
   input  wire logic        shared_in_pin_in,   // enable pin or comparator input
   output logic             shared_out_pin_out, // power-good or comparator output
   // power path controls
   output logic             adapter_isolation_gate_out,
   output logic             battery_path_gate_out,
   output logic             adapter_present_flag_out,
   output logic             switching_en_out,
   output logic             regulator_en_out,
   output logic             otg_run_out
);
   // control registers
   logic [15:0] ctl1_ff;                 // first control word
   logic [15:0] ctl2_ff;                 // second control word
   // fault state
   logic        ain_ov_ff;               // adapter overvoltage latched
   logic        sys_ov_ff;               // system overvoltage latched
   logic        hot_ff;                  // over-temperature latched
   cfpm_guard_t grd_state_ff;            // overcurrent guard state
   logic [31:0] smp_cnt_ff;              // sampling interval timer
   logic        smp_hit_ff;              // a count already taken this interval
   logic [2:0]  evt_cnt_ff;              // overcurrent event count
   logic [31:0] win_cnt_ff;              // counting window timer
   logic [31:0] deb_cnt_ff;              // retry debounce timer
   // output registers
   logic        pin_out_ff;
   logic        iso_ff;
   logic        bpath_ff;
   logic        flag_ff;
   logic        sw_ff;
   logic        reg_ff;
   logic        otg_ff;
   logic [15:0] rdata_ff;

   // decoded controls
   wire         otg_enable    = ctl1_ff[CTL1_OTG_EN_BIT];
   wire         cmp_disable   = ctl2_ff[CTL2_CMP_DIS_BIT];
   wire         cmp_invert    = ctl2_ff[CTL2_CMP_INV_BIT];
   wire         guard_off     = ctl2_ff[CTL2_GUARD_OFF];
   wire         short_deb     = ctl2_ff[CTL2_SHORT_DEB];
   wire         pins_cmp      = !cmp_disable;
   wire         pins_otg      = otg_enable && cmp_disable;
   wire         host_port_enable_level = shared_in_pin_in;
   wire         cmp_level     = cmp_above_ref_in ^ cmp_invert;
   wire         host_port_power_good   = otg_ff && otg_in_window_in;
   // otg run: comparator mode needs only battery; pin mode also needs enable
   wire         nxt_otg = otg_enable && bat_above_otg_in &&
                          (!cmp_disable || host_port_enable_level);
   // pin output: comparator, power-good, or idle low
   wire         nxt_pin = pins_cmp ? cmp_level :
                          pins_otg ? host_port_power_good : 1'b0;
   // qualified adapter levels
   wire         ain_set;
   wire         ain_clr;
   wire         temp_ok;
   wire         overcurrent_event = adp_cur_over_in || bat_cur_over_in;
   wire         grd_tripped   = grd_state_ff != GRD_RUN;
   wire         smp_end       = smp_cnt_ff >= 32'(GUARD_SMP_CYC - 1);
   wire         win_end       = win_cnt_ff >= 32'(WIN_CYC - 1);
   wire         take_cnt      = overcurrent_event && !smp_hit_ff && !guard_off;
   wire         reach_limit   = take_cnt && (evt_cnt_ff == 3'(GUARD_LIMIT - 1));
   wire [31:0]  deb_target    = short_deb ? 32'(SHORT_CYC) : 32'(LONG_CYC);
   wire         reg_sel1      = reg_wr_in && (reg_addr_in == REG_FIRST_CTRL);
   wire         reg_sel2      = reg_wr_in && (reg_addr_in == REG_SECOND_CTRL);
   // information word: otg mode field
   wire [15:0]  info_word = {9'h000, (otg_ff ? INFO_MODE_OTG : 2'h0), 5'h00};
   wire [15:0]  nxt_rdata = (reg_addr_in == REG_STATUS_INFO) ? info_word :
                            (reg_addr_in == REG_FIRST_CTRL)  ? ctl1_ff :
                            (reg_addr_in == REG_SECOND_CTRL) ? ctl2_ff : 16'h0000;
   // switching waits for every fault to clear
   wire         any_fault = ain_ov_ff || sys_ov_ff || hot_ff || grd_tripped;

   // adapter above threshold longer than qualification time
   cfpm_qualifier #(.CYCLES(AIN_QUAL_CYC)) u_ain_set
   (
      .ref_clk_in (ref_clk_in),
      .rst_in     (rst_in),
      .cond_in    (ain_over_in),
      .met_out    (ain_set)
   );

   // adapter below release longer than recovery time
   cfpm_qualifier #(.CYCLES(AIN_REL_CYC)) u_ain_clr
   (
      .ref_clk_in (ref_clk_in),
      .rst_in     (rst_in),
      .cond_in    (ain_below_rel_in),
      .met_out    (ain_clr)
   );

   // cool for the fixed delay before the regulator returns
   cfpm_qualifier #(.CYCLES(TEMP_DLY_CYC)) u_temp_ok
   (
      .ref_clk_in (ref_clk_in),
      .rst_in     (rst_in),
      .cond_in    (temp_cool_in && !temp_hot_in),
      .met_out    (temp_ok)
   );

   // control registers
   always_ff @(posedge ref_clk_in)
   begin
      if (rst_in)
      begin
         ctl1_ff <= CTL1_RESET;
         ctl2_ff <= CTL2_RESET;
      end
      else
      begin
         if (reg_sel1)
            ctl1_ff <= reg_wdata_in;
         if (reg_sel2)
            ctl2_ff <= reg_wdata_in;
      end
   end

   // adapter, system and temperature fault latches
   always_ff @(posedge ref_clk_in)
   begin
      if (rst_in)
      begin
         ain_ov_ff <= 1'b0;
         sys_ov_ff <= 1'b0;
         hot_ff    <= 1'b0;
      end
      else
      begin
         // a set wins over a release in the same cycle
         if (ain_set)
            ain_ov_ff <= 1'b1;
         else if (ain_clr)
            ain_ov_ff <= 1'b0;
         if (sys_over_in)
            sys_ov_ff <= 1'b1;
         else if (sys_below_hys_in)
            sys_ov_ff <= 1'b0;
         if (temp_hot_in)
            hot_ff <= 1'b1;
         else if (temp_ok)
            hot_ff <= 1'b0;
      end
   end

   // sampling interval timer: one count allowed per interval
   always_ff @(posedge ref_clk_in)
   begin
      if (rst_in || smp_end)
      begin
         smp_cnt_ff <= 32'h00000000;
         smp_hit_ff <= 1'b0;
      end
      else
      begin
         smp_cnt_ff <= smp_cnt_ff + 32'h00000001;
         if (take_cnt)
            smp_hit_ff <= 1'b1;
      end
   end

   // overcurrent guard: count, trip, debounce, retry
   always_ff @(posedge ref_clk_in)
   begin
      if (rst_in)
      begin
         grd_state_ff <= GRD_RUN;
         evt_cnt_ff   <= 3'h0;
         win_cnt_ff   <= 32'h00000000;
         deb_cnt_ff   <= 32'h00000000;
      end
      else
      begin
         case (grd_state_ff)
            GRD_RUN:
            begin
               // window restarts the count when it expires, unless a count is taken in that cycle
               win_cnt_ff <= win_end ? 32'h00000000 : win_cnt_ff + 32'h00000001;
               if (guard_off)
                  evt_cnt_ff <= 3'h0;
               else if (reach_limit)
               begin
                  grd_state_ff <= GRD_TRIP;
                  evt_cnt_ff   <= 3'h0;
               end
               else if (take_cnt)
                  evt_cnt_ff <= evt_cnt_ff + 3'h1;
               else if (win_end)
                  evt_cnt_ff <= 3'h0;
            end
            GRD_TRIP:
            begin
               deb_cnt_ff   <= 32'h00000000;
               grd_state_ff <= GRD_RETRY;
            end
            GRD_RETRY:
            begin
               // wait debounce, then rerun start-up
               deb_cnt_ff <= deb_cnt_ff + 32'h00000001;
               if (deb_cnt_ff >= deb_target)
               begin
                  grd_state_ff <= GRD_RUN;
                  win_cnt_ff   <= 32'h00000000;
               end
            end
            default:
               grd_state_ff <= GRD_RUN;
         endcase
      end
   end

   // registered outputs
   always_ff @(posedge ref_clk_in)
   begin
      if (rst_in)
      begin
         pin_out_ff <= 1'b0;
         iso_ff     <= 1'b0;
         bpath_ff   <= 1'b0;
         flag_ff    <= 1'b0;
         sw_ff      <= 1'b0;
         reg_ff     <= 1'b0;
         otg_ff     <= 1'b0;
         rdata_ff   <= 16'h0000;
      end
      else
      begin
         otg_ff     <= nxt_otg;
         pin_out_ff <= nxt_pin;
         // gate open and flag low on adapter or overcurrent fault
         iso_ff     <= !(ain_set || ain_ov_ff || reach_limit || grd_tripped);
         flag_ff    <= !(ain_set || ain_ov_ff || reach_limit || grd_tripped);
         // battery carries the system while adapter overvoltage cuts the adapter off, not on an overcurrent trip
         bpath_ff   <= ain_set || ain_ov_ff;
         // any active fault holds switching off until all release
         sw_ff      <= !(any_fault || ain_set || reach_limit ||
                         temp_hot_in || sys_over_in);
         reg_ff     <= !(hot_ff || temp_hot_in);
         rdata_ff   <= nxt_rdata;
      end
   end

   // every port comes straight from its register
   assign reg_rdata_out              = rdata_ff;
   assign shared_out_pin_out         = pin_out_ff;
   assign adapter_isolation_gate_out = iso_ff;
   assign battery_path_gate_out      = bpath_ff;
   assign adapter_present_flag_out   = flag_ff;
   assign switching_en_out           = sw_ff;
   assign regulator_en_out           = reg_ff;
   assign otg_run_out                = otg_ff;
endmodule : cfpm_top

// ===== tb/cfpm_props.sv
`timescale 1ns/1ps
// port checks of the fault and pin-mux block
module cfpm_props
   import cfpm_pkg::*;
(
   // clock, reset, register port
   input wire logic        ref_clk_in,
   input wire logic        rst_in,
   input wire logic        reg_wr_in,
   input wire logic [7:0]  reg_addr_in,
   input wire logic [15:0] reg_wdata_in,
   input wire logic [15:0] reg_rdata_out,
   // levels and shared pins
   input wire logic        ain_over_in,
   input wire logic        adp_cur_over_in,
   input wire logic        bat_cur_over_in,
   input wire logic        sys_over_in,
   input wire logic        temp_cool_in,
   input wire logic        cmp_above_ref_in,
   input wire logic        shared_in_pin_in,
   input wire logic        shared_out_pin_out,
   // power path
   input wire logic        adapter_isolation_gate_out,
   input wire logic        battery_path_gate_out,
   input wire logic        adapter_present_flag_out,
   input wire logic        switching_en_out,
   input wire logic        regulator_en_out,
   input wire logic        otg_run_out
);
   wire logic   wr1 = reg_wr_in && reg_addr_in == REG_FIRST_CTRL;  // first word write
   wire logic   wr2 = reg_wr_in && reg_addr_in == REG_SECOND_CTRL; // second word write
   logic [15:0] c1_ff;   // shadow of first word
   logic [15:0] c2_ff;   // shadow of second word
   int          hi_ff;   // adapter high run length
   int          cool_ff; // junction cool run length
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   // shadows and run-length counters
   always_ff @(posedge ref_clk_in)
   begin
      c1_ff   <= rst_in ? CTL1_RESET : (wr1 ? reg_wdata_in : c1_ff);
      c2_ff   <= rst_in ? CTL2_RESET : (wr2 ? reg_wdata_in : c2_ff);
      hi_ff   <= (rst_in || !ain_over_in) ? 0 : hi_ff + 1;
      cool_ff <= (rst_in || !temp_cool_in) ? 0 : cool_ff + 1;
   end
   // pins serve the otg pair
   sequence s_pin_mode;
      c1_ff[CTL1_OTG_EN_BIT] && c2_ff[CTL2_CMP_DIS_BIT];
   endsequence
   AST_CMP_OUT: assert property (!c2_ff[CTL2_CMP_DIS_BIT] |=>
      shared_out_pin_out == ($past(cmp_above_ref_in) ^ $past(c2_ff[CTL2_CMP_INV_BIT])))
      else $error("comparator output wrong");
   AST_OTG_OFF: assert property (!c1_ff[CTL1_OTG_EN_BIT] |=> !otg_run_out)
      else $error("otg runs while disabled");
   AST_OTG_PIN: assert property (s_pin_mode ##0 !shared_in_pin_in |=> !otg_run_out)
      else $error("otg runs with enable pin low");
   AST_OTG_INFO: assert property (otg_run_out && reg_addr_in == REG_STATUS_INFO |=>
      reg_rdata_out[INFO_MODE_HI:INFO_MODE_LO] == INFO_MODE_OTG) else $error("mode field wrong");
   AST_AIN_LATE: assert property (hi_ff >= 102 |-> !adapter_isolation_gate_out &&
      battery_path_gate_out && !adapter_present_flag_out && !switching_en_out)
      else $error("adapter overvoltage not handled");
   AST_AIN_EARLY: assert property (hi_ff < 90 && ain_over_in && adapter_isolation_gate_out
      && !adp_cur_over_in && !bat_cur_over_in |=> adapter_isolation_gate_out)
      else $error("adapter overvoltage too early");
   AST_SYS_OV: assert property (sys_over_in |=> !switching_en_out)
      else $error("switching during rail overvoltage");
   AST_TEMP_HOLD: assert property (cool_ff inside {[1:899]} && !regulator_en_out |=>
      !regulator_en_out) else $error("regulator back too early");
endmodule : cfpm_props

// ===== tb/cfpm_supply_model.sv
`timescale 1ns/1ps
// adapter, die and otg output seen through comparators
module cfpm_supply_model
(
   // clock
   input  wire logic       ref_clk_in,
   // commanded conditions
   input  wire logic       ain_hi_in,    // adapter above upper threshold
   input  wire logic [1:0] temp_lvl_in,  // 0 cool, 1 band, 2 hot
   input  wire logic       otg_run_in,   // block drives otg output
   // comparator levels
   output logic            ain_over_out,
   output logic            ain_below_rel_out,
   output logic            temp_hot_out,
   output logic            temp_cool_out,
   output logic            otg_in_window_out
);
   logic [3:0] ramp_ff;  // otg output rise time
   // band sides are never both high
   assign ain_over_out      = ain_hi_in;
   assign ain_below_rel_out = !ain_hi_in;
   assign temp_hot_out      = temp_lvl_in == 2'h2;
   assign temp_cool_out     = temp_lvl_in == 2'h0;
   assign otg_in_window_out = ramp_ff == 4'hF;
   // output enters the window some cycles after start
   always_ff @(posedge ref_clk_in)
   begin
      ramp_ff <= !otg_run_in ? 4'h0 : ramp_ff + {3'h0, ramp_ff != 4'hF};
   end
endmodule : cfpm_supply_model

// ===== tb/cfpm_top_bench.sv
`timescale 1ns/1ps
// pin modes, faults and recoveries
module cfpm_top_bench;
   import cfpm_pkg::*;
   logic        clk, rst, wr, ain_hi, sys_hi, acur, bcur, bat_hi, cmp, pin;
   logic [1:0]  temp_lvl;                             // 0 cool, 1 band, 2 hot
   logic [7:0]  addr;
   logic [15:0] wdata, rdata;
   logic        ain_ov, ain_rel, t_hot, t_cool, win;  // partner levels
   logic        pout, gate, bpath, flag, sw, reg_en, otg;
   int          error_cnt = 0;
   int          checked = 0;
   int          n;
   cfpm_top #(.WIN_CYC(2000), .LONG_CYC(400), .SHORT_CYC(100)) cfpm_top_inst (
      .ref_clk_in(clk), .rst_in(rst), .reg_wr_in(wr), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_rdata_out(rdata), .ain_over_in(ain_ov),
      .ain_below_rel_in(ain_rel), .sys_over_in(sys_hi), .sys_below_hys_in(!sys_hi),
      .adp_cur_over_in(acur), .bat_cur_over_in(bcur), .temp_hot_in(t_hot),
      .temp_cool_in(t_cool), .bat_above_otg_in(bat_hi), .otg_in_window_in(win),
      .cmp_above_ref_in(cmp), .shared_in_pin_in(pin), .shared_out_pin_out(pout),
      .adapter_isolation_gate_out(gate), .battery_path_gate_out(bpath),
      .adapter_present_flag_out(flag), .switching_en_out(sw),
      .regulator_en_out(reg_en), .otg_run_out(otg));
   cfpm_supply_model cfpm_supply_model_inst (
      .ref_clk_in(clk), .ain_hi_in(ain_hi), .temp_lvl_in(temp_lvl), .otg_run_in(otg),
      .ain_over_out(ain_ov), .ain_below_rel_out(ain_rel), .temp_hot_out(t_hot),
      .temp_cool_out(t_cool), .otg_in_window_out(win));
   // 100 ns reference clock
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic test_done;
      $display("checked %0d error_cnt %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : test_done
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic chk_rng(input string what, input int lo, input int hi, input int got);
      checked++;
      if (got < lo || got > hi)
      begin
         error_cnt++;
         $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask : chk_rng
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
   endtask : tick
   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      wr    <= 1'b0;
   endtask : wr_reg
   // read data lands one edge after the address
   task automatic rd_chk(input string what, input logic [7:0] a, input logic [15:0] m,
                         input logic [15:0] e);
      @(posedge clk);
      addr <= a;
      @(posedge clk);
      #1 chk(what, e, rdata & m);
   endtask : rd_chk
   function automatic logic pick(input int s);
      case (s)
         0: return gate;
         1: return sw;
         default: return reg_en;
      endcase
   endfunction : pick
   // edges until an output reaches v, bounded
   task automatic wait_for(input int s, input logic v, input int lim, output int k);
      k = 0;
      #1;
      while (pick(s) !== v)
      begin
         @(posedge clk);
         #1 k++;
         if (k > lim)
         begin
            error_cnt++;
            $display("mismatch wait %0d expected %b seen timeout", s, v);
            test_done();
         end
      end
   endtask : wait_for
   task automatic t_regs;
      rd_chk("ctl1 reset", REG_FIRST_CTRL, 16'hFFFF, CTL1_RESET);
      rd_chk("ctl2 reset", REG_SECOND_CTRL, 16'hFFFF, CTL2_RESET);
      wr_reg(REG_FIRST_CTRL, 16'hA5F0);
      wr_reg(REG_SECOND_CTRL, 16'h5A06);
      wr_reg(8'h10, 16'hFFFF);
      wr_reg(REG_STATUS_INFO, 16'hFFFF);
      rd_chk("ctl1", REG_FIRST_CTRL, 16'hFFFF, 16'hA5F0);
      rd_chk("ctl2", REG_SECOND_CTRL, 16'hFFFF, 16'h5A06);
      rd_chk("unmapped", 8'h10, 16'hFFFF, 16'h0000);
      rd_chk("info idle", REG_STATUS_INFO, 16'h0060, 16'h0000);
      wr_reg(REG_FIRST_CTRL, 16'h0000);
      wr_reg(REG_SECOND_CTRL, 16'h0000);
   endtask : t_regs
   // all four pin modes, then polarity and power-good
   task automatic t_pins;
      logic [3:0] po = 4'b0101;
      logic [3:0] ro = 4'b0100;
      bat_hi <= 1'b1;
      cmp    <= 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         wr_reg(REG_FIRST_CTRL, i[1] ? 16'h0800 : 16'h0000);
         wr_reg(REG_SECOND_CTRL, i[0] ? 16'h0008 : 16'h0000);
         tick(4);
         #1 chk("shared out", {15'h0, po[i]}, {15'h0, pout});
         chk("otg run", {15'h0, ro[i]}, {15'h0, otg});
      end
      pin <= 1'b1;
      tick(25);
      #1 chk("power good", 16'h1, {15'h0, pout});
      rd_chk("otg mode", REG_STATUS_INFO, 16'h0060, 16'h0060);
      wr_reg(REG_SECOND_CTRL, 16'h0004);
      tick(4);
      #1 chk("inverted out", 16'h0, {15'h0, pout});
      rd_chk("otg mode cmp", REG_STATUS_INFO, 16'h0060, 16'h0060);
      wr_reg(REG_FIRST_CTRL, 16'h0000);
      wr_reg(REG_SECOND_CTRL, 16'h0000);
      bat_hi <= 1'b0;
      pin    <= 1'b0;
   endtask : t_pins
   task automatic t_ain;
      @(posedge clk);
      ain_hi <= 1'b1;
      wait_for(0, 1'b0, 200, n);
      chk_rng("adapter trip", 101, 104, n);
      chk("flag bpath sw", 16'h2, {13'h0, flag, bpath, sw});
      @(posedge clk);
      ain_hi <= 1'b0;
      wait_for(0, 1'b1, 1200, n);
      chk_rng("adapter release", 1001, 1004, n);
      wait_for(1, 1'b1, 3, n);
   endtask : t_ain
   task automatic t_sys;
      @(posedge clk);
      sys_hi <= 1'b1;
      wait_for(1, 1'b0, 3, n);
      chk("gate in rail fault", 16'h1, {15'h0, gate});
      @(posedge clk);
      sys_hi <= 1'b0;
      wait_for(1, 1'b1, 3, n);
   endtask : t_sys
   task automatic t_temp;
      @(posedge clk);
      temp_lvl <= 2'h2;
      sys_hi   <= 1'b1;
      wait_for(2, 1'b0, 3, n);
      chk("sw hot", 16'h0, {15'h0, sw});
      @(posedge clk);
      temp_lvl <= 2'h1;
      sys_hi   <= 1'b0;
      tick(1500);
      #1 chk("reg and sw band", 16'h0, {14'h0, reg_en, sw});
      @(posedge clk);
      temp_lvl <= 2'h0;
      wait_for(2, 1'b1, 1200, n);
      chk_rng("regulator return", 1001, 1004, n);
      wait_for(1, 1'b1, 3, n);
   endtask : t_temp
   // trip, retry with both debounces, then guard off
   task automatic t_oc;
      wr_reg(REG_SECOND_CTRL, 16'h0800);
      bcur <= 1'b1;
      wait_for(0, 1'b0, 3500, n);
      chk_rng("seven counts", 1200, 3400, n);
      chk("flag sw", 16'h0, {14'h0, flag, sw});
      @(posedge clk);
      bcur <= 1'b0;
      wait_for(0, 1'b1, 300, n);
      chk_rng("short retry", 95, 105, n);
      wr_reg(REG_SECOND_CTRL, 16'h0000);
      acur <= 1'b1;
      wait_for(0, 1'b0, 3500, n);
      chk_rng("seven counts", 1200, 3400, n);
      @(posedge clk);
      acur <= 1'b0;
      wait_for(0, 1'b1, 600, n);
      chk_rng("long retry", 395, 405, n);
      wr_reg(REG_SECOND_CTRL, 16'h0002);
      bcur <= 1'b1;
      tick(3000);
      #1 chk("guard off", 16'h3, {14'h0, gate, flag});
      @(posedge clk);
      bcur <= 1'b0;
   endtask : t_oc
   initial
   begin
      {rst, wr, ain_hi, sys_hi, acur, bcur, bat_hi, cmp, pin} = 9'h100;
      {temp_lvl, addr, wdata} = 26'h0;
      tick(1);
      #1 chk("outputs in reset", 16'h0, {9'h0, pout, gate, bpath, flag, sw, reg_en, otg});
      chk("rdata in reset", 16'h0, rdata);
      tick(1);
      rst <= 1'b0;
      t_regs();
      t_pins();
      t_ain();
      t_sys();
      t_temp();
      t_oc();
      test_done();
   end
endmodule : cfpm_top_bench
bind cfpm_top cfpm_props cfpm_props_inst (.*);
